// File: hw/shp_defines.vh
// Constants of the SPI host register port
`ifndef SHP_DEFINES_VH
`define SHP_DEFINES_VH
`define SHP_SEL_UART 2'h0
`define SHP_SEL_SPI 2'h2
`define SHP_SEL_I2C 2'h1
`define SHP_SEL_I2CL 2'h3
`define SHP_DIR_BIT 0
`define SHP_ADDR_MSB 7
`define SHP_ADDR_LSB 1
`define SHP_BIT_CNT_MAX 3'h7
`define SHP_STRAP_WAIT 2'h2
`define SHP_FIFO_ADDR_DEF 7'h05
`define SHP_MAX_RATE_KBPS 10000
`define SHP_CLK_MHZ 250
`endif

// File: hw/shp_sync.v
// Two-flop synchroniser for a group of input pins
`timescale 1ns/1ps
module shp_sync #(
  parameter WIDTH = 3
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_ff; // First stage, read only by the second
  reg [WIDTH-1:0] sync_ff; // Second stage, safe to use
  // Two stages, reset to all zeros
  always @(posedge clk) begin
    if (rst) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end
  assign dout = sync_ff;
endmodule // shp_sync

// File: hw/shp_port.v
// SPI slave port giving a host byte-wise access to the register space
// Function
// - Two straps select UART, SPI, I2C, I2C-alternate
// - Reset port, then sample straps after reset
// - Slave only; master drives SCK and MOSI
// - Link rate up to 10 Mbit/s
// - Slave select high resets and ignores link
// - Bytes shift most significant bit first
// - Device updates MISO on falling SCK edges
// - SCK idles low; sample on rising edge
// - Address byte: bit0 read flag, bits7-1 address
// - Read burst returns previous address data
// - Write: address then data; MISO meaningless
// - Burst write increments address per byte
// - FIFO address write never increments
`timescale 1ns/1ps
`include "shp_defines.vh"
module shp_port #(
  parameter [6:0] FIFO_ADDR = `SHP_FIFO_ADDR_DEF
) (
  input wire CLK_SYS,
  input wire RESET,
  input wire HOST_PORT_STRAP_ZERO,
  input wire HOST_PORT_STRAP_ONE,
  input wire SCK,
  input wire MOSI,
  input wire SLAVE_SELECT_N,
  output reg MISO,
  output reg MISO_OE,
  output reg [1:0] HOST_SEL,
  output reg SPI_ACTIVE,
  output reg [6:0] REG_ADDR,
  output reg [7:0] REG_WDATA,
  output reg REG_WR,
  output reg REG_RD,
  input wire [7:0] REG_RDATA
);
  // Link rate budget: at 250 MHz a 10 Mbit/s bit lasts 25 cycles, so each SCK
  // phase spans about twelve cycles. An edge reaches the sequencer after the two
  // sync flops, as the detect compares against the held previous level, and MISO
  // moves one cycle later: about three cycles of the twelve. A faster link keeps this sync depth while each phase outlasts three cycles.
  localparam [1:0] ST_ADDR = 2'h0;  // Awaiting address byte
  localparam [1:0] ST_READ = 2'h1;  // Read burst in progress
  localparam [1:0] ST_WRITE = 2'h2; // Write burst in progress

  wire [4:0] pins_s; // Synchronised pins: straps, sck, mosi, select
  reg sck_d_ff; // Previous synchronised SCK for edge detection
  reg [1:0] state_ff; // Command sequencer
  reg [2:0] bit_cnt_ff; // Bits received in current byte
  reg [6:0] shift_in_ff; // Received bits, MSB first
  reg [7:0] shift_out_ff; // Byte being presented on MISO
  reg [1:0] strap_wait_ff; // Cycles since reset release, saturating
  reg rd_pend_ff; // Read data must be loaded next cycle
  reg [6:0] wr_addr_ff; // Next write target

  wire sck_s = pins_s[2];
  wire mosi_s = pins_s[1];
  wire sel_n_s = pins_s[0];
  wire sck_rise = sck_s & ~sck_d_ff;
  wire sck_fall = ~sck_s & sck_d_ff;
  wire [7:0] byte_in = {shift_in_ff, mosi_s};
  wire spi_mode = (HOST_SEL == `SHP_SEL_SPI);

  // Register address field of a received byte; used by the address and read states
  function [6:0] addr_of;
    input [7:0] b;
    begin
      addr_of = b[`SHP_ADDR_MSB:`SHP_ADDR_LSB];
    end
  endfunction

  // All pins cross into the system clock through two flops.
  // SCK, MOSI and select share one stage chain, so the order in which they
  // change on the wire is kept; the straps are levels and the delay is harmless.
  shp_sync #(.WIDTH(5)) u_sync (
    .clk(CLK_SYS),
    .rst(RESET),
    .din({HOST_PORT_STRAP_ONE, HOST_PORT_STRAP_ZERO, SCK, MOSI, SLAVE_SELECT_N}),
    .dout(pins_s)
  );

  // Strap capture: the synchroniser is cleared by reset as well, so its output
  // shows the real strap levels only from the second edge after release.
  // Taking the straps any earlier would latch the cleared value as UART.
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      strap_wait_ff <= 2'h0;
      HOST_SEL <= `SHP_SEL_UART;
      SPI_ACTIVE <= 1'b0;
    end else begin
      // Count up once, then rest until the next reset
      if (strap_wait_ff != 2'h3) begin
        strap_wait_ff <= strap_wait_ff + 2'h1;
      end
      // Both stages now hold pin levels sampled after release
      if (strap_wait_ff == `SHP_STRAP_WAIT) begin
        // Strap one is high bit, strap zero low bit of the select code
        HOST_SEL <= {pins_s[4], pins_s[3]};
        SPI_ACTIVE <= ({pins_s[4], pins_s[3]} == `SHP_SEL_SPI);
      end
    end
  end

  // Link engine: shifts on SCK edges found by the system clock.
  // Read data must come back within one cycle of REG_RD, because the first
  // MISO bit of the next slot leaves on the very next detected SCK fall.
  // The edge detector resets to zero, the idle level of SCK, so no false
  // rising edge follows reset.
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      // Outputs quiet and sequencer at the address byte while in reset
      sck_d_ff <= 1'b0;
      state_ff <= ST_ADDR;
      bit_cnt_ff <= 3'h0;
      shift_in_ff <= 7'h00;
      shift_out_ff <= 8'h00;
      rd_pend_ff <= 1'b0;
      wr_addr_ff <= 7'h00;
      MISO <= 1'b0;
      MISO_OE <= 1'b0;
      REG_ADDR <= 7'h00;
      REG_WDATA <= 8'h00;
      REG_WR <= 1'b0;
      REG_RD <= 1'b0;
    end else begin
      sck_d_ff <= sck_s;
      REG_WR <= 1'b0;
      REG_RD <= 1'b0;
      if (sel_n_s | ~spi_mode) begin
        // Deselected: sequencer held reset, partial byte dropped.
        // A cut byte never reaches the strobe logic, so no half write lands.
        state_ff <= ST_ADDR;
        bit_cnt_ff <= 3'h0;
        rd_pend_ff <= 1'b0;
        shift_out_ff <= 8'h00;
        MISO_OE <= 1'b0;
        MISO <= 1'b0;
      end else begin
        MISO_OE <= 1'b1;
        // Register read data arrives one cycle after the strobe
        if (rd_pend_ff) begin
          rd_pend_ff <= 1'b0;
          shift_out_ff <= REG_RDATA;
        end
        if (sck_rise) begin
          // Sample MOSI on the rising edge
          shift_in_ff <= byte_in[6:0];
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
          if (bit_cnt_ff == `SHP_BIT_CNT_MAX) begin
            // Full byte received; only now act on it
            case (state_ff)
              ST_ADDR: begin
                // First byte of a frame: bit 0 picks read or write
                if (byte_in[`SHP_DIR_BIT]) begin
                  // Read: strobe now, data lands in the next cycle
                  state_ff <= ST_READ;
                  REG_ADDR <= addr_of(byte_in);
                  REG_RD <= 1'b1;
                  rd_pend_ff <= 1'b1;
                end else begin
                  // Write: keep the address until the first data byte
                  state_ff <= ST_WRITE;
                  wr_addr_ff <= addr_of(byte_in);
                end
              end
              ST_READ: begin
                // Each slot names the next address; 00h also strobes a read of address 00h
                REG_ADDR <= addr_of(byte_in);
                REG_RD <= 1'b1;
                rd_pend_ff <= 1'b1;
              end
              ST_WRITE: begin
                // Whole byte in hand: commit it at the running address
                // The FIFO address stays put so a burst streams into it
                REG_ADDR <= wr_addr_ff;
                REG_WDATA <= byte_in;
                REG_WR <= 1'b1;
                if (wr_addr_ff != FIFO_ADDR) begin
                  wr_addr_ff <= wr_addr_ff + 7'h01;
                end else begin
                  wr_addr_ff <= wr_addr_ff;
                end
              end
              default: begin
                // Unused code: fall back to waiting for an address
                state_ff <= ST_ADDR;
              end
            endcase
          end
        end
        if (sck_fall) begin
          // MISO moves on falling edge; stable across next rise
          if (bit_cnt_ff == 3'h0) begin
            // Byte boundary: present MSB of loaded data; write gives zero
            MISO <= (state_ff == ST_READ) ? shift_out_ff[7] : 1'b0;
          end else begin
            MISO <= (state_ff == ST_READ) ? shift_out_ff[7] : 1'b0;
          end
          if (state_ff == ST_READ) begin
            shift_out_ff <= {shift_out_ff[6:0], 1'b0};
          end
        end
      end
    end
  end
endmodule // shp_port

// File: verif/shp_port_assertions.sv
// Checker of the SPI host register port
`timescale 1ns/1ps
module shp_chk #(
  parameter [6:0] FIFO_ADDR = 7'h05
) (
  input wire CLK_SYS,
  input wire RESET,
  input wire HOST_PORT_STRAP_ZERO,
  input wire HOST_PORT_STRAP_ONE,
  input wire SCK,
  input wire SLAVE_SELECT_N,
  input wire MISO,
  input wire MISO_OE,
  input wire [1:0] HOST_SEL,
  input wire SPI_ACTIVE,
  input wire [6:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  reg [6:0] exp_ff; // Address the next burst write must use
  reg have_ff; // A write was seen in this frame
  // Track the expected address; a high select ends the burst
  always @(posedge CLK_SYS) begin
    if (RESET || SLAVE_SELECT_N)
      have_ff <= 1'b0;
    else if (REG_WR)
      have_ff <= 1'b1;
    if (REG_WR)
      exp_ff <= REG_ADDR + {6'h0, REG_ADDR != FIFO_ADDR};
  end
  property p_sel; $fell(RESET) |-> ##[1:3] HOST_SEL == {HOST_PORT_STRAP_ONE, HOST_PORT_STRAP_ZERO}; endproperty
  property p_act; $stable(HOST_SEL) [*2] |-> SPI_ACTIVE == (HOST_SEL == 2'h2); endproperty
  property p_idle; SLAVE_SELECT_N [*6] |-> !REG_WR && !REG_RD && !MISO_OE; endproperty
  property p_slave; MISO_OE |-> SPI_ACTIVE; endproperty
  property p_dir; REG_WR |-> SPI_ACTIVE && !REG_RD; endproperty
  property p_pulse; REG_WR || REG_RD |=> !REG_WR && !REG_RD; endproperty
  property p_miso; SCK [*4] |-> $stable(MISO); endproperty
  property p_inc; REG_WR && have_ff |-> REG_ADDR == exp_ff; endproperty
  a_sel: assert property (p_sel) else $error("host select mismatch");
  a_act: assert property (p_act) else $error("spi active mismatch");
  a_idle: assert property (p_idle) else $error("activity while deselected");
  a_slave: assert property (p_slave) else $error("miso driven outside spi");
  a_dir: assert property (p_dir) else $error("bad write strobe");
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  a_miso: assert property (p_miso) else $error("miso moved while sck high");
  a_inc: assert property (p_inc) else $error("burst address wrong");
  c_wr: cover property (REG_WR);
  c_rd: cover property (REG_RD);
  c_fifo: cover property (REG_WR && REG_ADDR == FIFO_ADDR);
endmodule // shp_chk
bind shp_port shp_chk #(.FIFO_ADDR(FIFO_ADDR)) u_chk (.*);

// File: verif/shp_host.sv
// Behavioural SPI master standing in for the host
`timescale 1ns/1ps
module shp_host (
  output logic sck,
  output logic mosi,
  output logic ss_n,
  input wire miso
);
  initial begin
    sck = 0; // Clock idles low
    mosi = 0;
    ss_n = 1;
  end
  // Shift bits MSB first, change on fall, sample on rise
  task automatic xfer(input [7:0] tx, input int nb, output [7:0] rx);
    for (int i = 7; i > 7 - nb; i--) begin
      mosi = tx[i];
      #24 sck = 1;
      rx = {rx[6:0], miso};
      #24 sck = 0;
    end
    mosi = ~mosi; // Old bit is not held past its slot
  endtask
  // Select framing; raised between commands
  task automatic sel(input bit on);
    #24 ss_n = !on;
  endtask
endmodule // shp_host

// File: verif/testbench.sv
// Self-checking bench of the SPI host register port
`timescale 1ns/1ps
module testbench;
  localparam [6:0] F = 7'h11; // FIFO address of this run
  logic clk = 0, rst = 1, z = 0, o = 1;
  wire sck, mosi, ss_n, miso, wr, rd;
  wire [1:0] hsel;
  wire [6:0] addr;
  wire [7:0] wd;
  wire [7:0] rdata = {addr, 1'b1} ^ 8'h5A; // Read data derived from address
  logic [14:0] wq[$];
  logic [6:0] rq[$];
  logic [7:0] r;
  int num_errors = 0, checks_done = 0;
  always #2 clk = ~clk;
  always @(posedge clk) if (wr) wq.push_back({addr, wd}); // Log each commit
  always @(posedge clk) if (rd) rq.push_back(addr); // Log each read strobe
  shp_host u_host (.sck(sck), .mosi(mosi), .ss_n(ss_n), .miso(miso));
  shp_port #(.FIFO_ADDR(F)) u_dut (.CLK_SYS(clk), .RESET(rst), .HOST_PORT_STRAP_ZERO(z),
    .HOST_PORT_STRAP_ONE(o), .SCK(sck), .MOSI(mosi), .SLAVE_SELECT_N(ss_n), .MISO(miso),
    .MISO_OE(), .HOST_SEL(hsel), .SPI_ACTIVE(), .REG_ADDR(addr), .REG_WDATA(wd),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));
  task chk(input [14:0] seen, input [14:0] exp, input string nm);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task conclude;
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task rst_to(input bit zz, input bit oo);
    @(posedge clk);
    z <= zz;
    o <= oo;
    rst <= 1;
    repeat (10) @(posedge clk);
    rst <= 0;
    repeat (4) @(posedge clk);
  endtask
  // Write burst; cut adds a half byte before deselect
  task wr_burst(input [6:0] a, input int n, input bit cut);
    wq.delete();
    u_host.sel(1);
    u_host.xfer({a, 1'b0}, 8, r);
    for (int i = 0; i < n; i++) u_host.xfer(8'hC0 + i[7:0], 8, r);
    if (cut) u_host.xfer(8'hFF, 4, r);
    u_host.sel(0);
    repeat (12) @(posedge clk);
  endtask
  task t_straps;
    for (int k = 0; k < 4; k++) begin
      rst_to(k[0], k[1]);
      chk(15'(hsel), 15'(k[1:0]), "host_sel");
      wr_burst(7'h30, 1, 0);
      chk(15'(wq.size()), 15'(k == 2), "writes");
    end
    rst_to(0, 1);
  endtask
  task t_write(input [6:0] a);
    wr_burst(a, 3, 1);
    chk(15'(wq.size()), 15'd3, "count");
    for (int i = 0; i < 3; i++) chk(wq[i], {a == F ? a : a + i[6:0], 8'hC0 + i[7:0]}, "write");
  endtask
  task t_read;
    rq.delete();
    u_host.sel(1);
    u_host.xfer({7'h21, 1'b1}, 8, r);
    u_host.xfer({7'h40, 1'b1}, 8, r);
    chk(15'(r), 15'(8'h43 ^ 8'h5A), "rd0");
    u_host.xfer(8'h00, 8, r);
    chk(15'(r), 15'(8'h81 ^ 8'h5A), "rd1");
    u_host.sel(0);
    repeat (4) @(posedge clk);
    chk(15'(rq.size()), 15'd3, "reads");
    for (int i = 0; i < rq.size() && i < 3; i++)
      chk(15'(rq[i]), 15'(i == 0 ? 7'h21 : i == 1 ? 7'h40 : 7'h00), "raddr");
  endtask
  initial begin
    t_straps;
    t_write(7'h7D);
    t_write(F);
    t_read;
    conclude;
  end
  initial begin
    #300000;
    num_errors++;
    conclude;
  end
endmodule // testbench
